// ---- hdl/vhm_regs.svh ----
`ifndef VHM_REGS_SVH
`define VHM_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define VHM_OFS_CTRL   8'h00
`define VHM_OFS_VTHR   8'h04
`define VHM_OFS_ITHR   8'h08
`define VHM_OFS_TMAX   8'h0c
`define VHM_OFS_STAT   8'h10
`define VHM_OFS_EVST   8'h14
`define VHM_OFS_EVCLR  8'h18
`define VHM_OFS_EVEN   8'h1c

// ****************************************
// Control fields and reset values
// ****************************************
`define VHM_BIT_EN     0
`define VHM_BIT_ISEL   1
`define VHM_BIT_FCT    2
`define VHM_CTRL_RST   3'h0
`define VHM_VTHR_MIN   16'h00c8
`define VHM_VTHR_MAX   16'h1388
`define VHM_VTHR_RST   16'h03e8
`define VHM_ITHR_RST   16'h0064
`define VHM_TMAX_MIN   16'h0002
`define VHM_TMAX_MAX   16'h1388
`define VHM_TMAX_RST   13'h0032

// ****************************************
// Event bits: even = on, odd = off
// ****************************************
`define VHM_EV_EN      0
`define VHM_EV_VLOW    2
`define VHM_EV_IHIGH   4
`define VHM_EV_CT      6
`define VHM_EV_HOLD    8
`define VHM_EV_BLK     10
`define VHM_EV_NUM     12

// ****************************************
// Timing
// ****************************************
`define VHM_TICK_NS    10000000
`define VHM_CLK_NS     50

`endif

// ---- hdl/vhm_pkg.sv ----
package vhm_pkg;
    typedef enum logic [1:0] {
        VHM_OFF  = 2'b00,
        VHM_ARM  = 2'b01,
        VHM_HOLD = 2'b10,
        VHM_DONE = 2'b11
    } vhm_state_t;
endpackage : vhm_pkg

// ---- hdl/vhm_timer.sv ----
`timescale 1ns/1ps
module vhm_timer #(
    parameter int P_TICK_CYC = 200000,
    parameter int P_CNT_W    = 13
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_run,
    input  wire logic [P_CNT_W-1:0] i_limit,
    output logic                    o_expired
);
    localparam int PW = $clog2(P_TICK_CYC + 1);

    logic [PW-1:0]      pre_reg;
    logic [PW-1:0]      pre_next;
    logic [P_CNT_W-1:0] cnt_reg;
    logic [P_CNT_W-1:0] cnt_next;
    logic               exp_reg;
    logic               exp_next;

    // Tick prescaler and definite-time count
    always_comb begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        if (!i_run) begin
            pre_next = '0;
            cnt_next = '0;
        end else if (pre_reg == PW'(P_TICK_CYC - 1)) begin
            pre_next = '0;
            if (cnt_reg < i_limit) begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else begin
            pre_next = pre_reg + 1'b1;
        end
        exp_next = i_run && (cnt_next >= i_limit);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign o_expired = exp_reg;
endmodule : vhm_timer

// ---- hdl/vhm_top.sv ----
// Notes on behaviour
// - Enable bit; when off, memorised quantities are never substituted.
// - Activation needs every used voltage below the activation threshold.
// - With current condition chosen, one phase current must exceed pick-up.
// - Activation threshold held within 2 to 50 V.
// - During hold the amplitude output equals the activation threshold.
// - During hold the angle output is the one captured before activation.
// - Hold-active output stays high for the whole hold.
// - Hold time bounded by a 0.02 to 50.00 s definite-time limit.
// - Blocking input sampled at each program cycle start; blocks the hold.
// - Forced tracking with voltages gone raises the tracking output o_ct_track.
// - On and off events for enable, low V, high I, tracking, hold, block.
`timescale 1ns/1ps
`include "vhm_regs.svh"
module vhm_top
    import vhm_pkg::*;
#(
    parameter int P_W        = 16,
    parameter int P_TICK_CYC = `VHM_TICK_NS / `VHM_CLK_NS
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic [7:0]          i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [31:0]         i_avs_writedata,
    output logic      [31:0]         o_avs_readdata,
    output logic                     o_avs_waitrequest,
    input  wire logic                i_cycle_start,
    input  wire logic                i_block,
    input  wire logic [2:0]          i_v_used,
    input  wire logic [2:0][P_W-1:0] i_v_mag,
    input  wire logic [2:0][P_W-1:0] i_v_ang,
    input  wire logic [2:0][P_W-1:0] i_i_mag,
    output logic      [2:0][P_W-1:0] o_v_mag,
    output logic      [2:0][P_W-1:0] o_v_ang,
    output logic                     o_hold_active,
    output logic                     o_ct_track,
    output logic                     o_irq
);
    localparam int NE = `VHM_EV_NUM;

    // ****************************************
    // Declarations
    // ****************************************
    logic [2:0]          ctrl_reg;
    logic [2:0]          ctrl_next;
    logic [P_W-1:0]      vthr_reg;
    logic [P_W-1:0]      vthr_next;
    logic [P_W-1:0]      ithr_reg;
    logic [P_W-1:0]      ithr_next;
    logic [12:0]         tmax_reg;
    logic [12:0]         tmax_next;
    logic [NE-1:0]       evst_reg;
    logic [NE-1:0]       evst_next;
    logic [NE-1:0]       even_reg;
    logic [NE-1:0]       even_next;
    logic [NE-1:0]       evt;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic                wait_reg;
    logic                wait_next;
    logic                irq_reg;
    logic                irq_next;
    logic                req;
    logic                wr_take;
    logic [15:0]         wv;
    vhm_state_t          state_reg;
    vhm_state_t          state_next;
    logic                hold_reg;
    logic                hold_next;
    logic                blk_reg;
    logic                blk_next;
    logic                vlow_reg;
    logic                vlow_next;
    logic                ihigh_reg;
    logic                ihigh_next;
    logic                ct_reg;
    logic                ct_next;
    logic [5:0]          flg_now;
    logic [5:0]          flg_prev;
    logic [2:0]          ph_low;
    logic [2:0]          ph_high;
    logic                all_low;
    logic                any_high;
    logic                act_cond;
    logic                tmr_exp;
    logic [2:0][P_W-1:0] pre_ang_reg;
    logic [2:0][P_W-1:0] pre_ang_next;
    logic [2:0][P_W-1:0] vmag_reg;
    logic [2:0][P_W-1:0] vmag_next;
    logic [2:0][P_W-1:0] vang_reg;
    logic [2:0][P_W-1:0] vang_next;

    // ****************************************
    // Per-phase comparisons and output muxes
    // ****************************************
    for (genvar g = 0; g < 3; g++) begin : g_ph
        assign ph_low[g]       = !i_v_used[g] || (i_v_mag[g] < vthr_reg);
        assign ph_high[g]      = i_i_mag[g] > ithr_reg;
        assign vmag_next[g]    = hold_next ? vthr_reg : i_v_mag[g];
        assign vang_next[g]    = hold_next ? pre_ang_reg[g] : i_v_ang[g];
        assign pre_ang_next[g] = (i_cycle_start && !hold_next) ?
                                 i_v_ang[g] : pre_ang_reg[g];
    end

    assign all_low  = (&ph_low) && (|i_v_used);
    assign any_high = |ph_high;
    assign act_cond = all_low && (!ctrl_reg[`VHM_BIT_ISEL] || any_high);

    // ****************************************
    // Hold state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        blk_next   = i_cycle_start ? i_block : blk_reg;
        vlow_next  = i_cycle_start ? all_low : vlow_reg;
        ihigh_next = i_cycle_start ? any_high : ihigh_reg;
        if (!ctrl_reg[`VHM_BIT_EN]) begin
            state_next = VHM_OFF;
        end else begin
            case (state_reg)
                VHM_OFF: begin
                    state_next = VHM_ARM;
                end
                VHM_ARM: begin
                    if (i_cycle_start && !i_block && act_cond) begin
                        state_next = VHM_HOLD;
                    end
                end
                VHM_HOLD: begin
                    if (blk_next) begin
                        state_next = VHM_ARM;
                    end else if (tmr_exp) begin
                        state_next = VHM_DONE;
                    end
                end
                VHM_DONE: begin
                    if (i_cycle_start && !act_cond) begin
                        state_next = VHM_ARM;
                    end
                end
                default: begin
                    state_next = VHM_OFF;
                end
            endcase
        end
        hold_next = (state_next == VHM_HOLD);
        ct_next   = ctrl_reg[`VHM_BIT_EN] && ctrl_reg[`VHM_BIT_FCT]
                    && vlow_next;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg   <= VHM_OFF;
            hold_reg    <= 1'b0;
            blk_reg     <= 1'b0;
            vlow_reg    <= 1'b0;
            ihigh_reg   <= 1'b0;
            ct_reg      <= 1'b0;
            pre_ang_reg <= '0;
            vmag_reg    <= '0;
            vang_reg    <= '0;
        end else begin
            state_reg   <= state_next;
            hold_reg    <= hold_next;
            blk_reg     <= blk_next;
            vlow_reg    <= vlow_next;
            ihigh_reg   <= ihigh_next;
            ct_reg      <= ct_next;
            pre_ang_reg <= pre_ang_next;
            vmag_reg    <= vmag_next;
            vang_reg    <= vang_next;
        end
    end

    vhm_timer #(
        .P_TICK_CYC (P_TICK_CYC),
        .P_CNT_W    (13)
    ) u_timer (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_run      (hold_reg),
        .i_limit    (tmax_reg),
        .o_expired  (tmr_exp)
    );

    // ****************************************
    // Events: rising edge even bit, falling odd
    // ****************************************
    assign flg_now = {blk_reg, hold_reg, ct_reg, ihigh_reg, vlow_reg,
                      ctrl_reg[`VHM_BIT_EN]};
    for (genvar e = 0; e < 6; e++) begin : g_ev
        assign evt[2*e]   = flg_now[e] && !flg_prev[e];
        assign evt[2*e+1] = !flg_now[e] && flg_prev[e];
    end

    // ****************************************
    // Avalon-MM slave, one wait state
    // ****************************************
    assign req     = i_avs_read || i_avs_write;
    assign wr_take = i_avs_write && !wait_reg;
    assign wv      = i_avs_writedata[15:0];

    always_comb begin
        ctrl_next  = ctrl_reg;
        vthr_next  = vthr_reg;
        ithr_next  = ithr_reg;
        tmax_next  = tmax_reg;
        even_next  = even_reg;
        evst_next  = evst_reg;
        rdata_next = rdata_reg;
        wait_next  = !(req && wait_reg);
        if (wr_take) begin
            case (i_avs_address)
                `VHM_OFS_CTRL: ctrl_next = i_avs_writedata[2:0];
                `VHM_OFS_VTHR: begin
                    if (wv < `VHM_VTHR_MIN) begin
                        vthr_next = `VHM_VTHR_MIN;
                    end else if (wv > `VHM_VTHR_MAX) begin
                        vthr_next = `VHM_VTHR_MAX;
                    end else begin
                        vthr_next = wv;
                    end
                end
                `VHM_OFS_ITHR: ithr_next = wv;
                `VHM_OFS_TMAX: begin
                    if (wv < `VHM_TMAX_MIN) begin
                        tmax_next = 13'(`VHM_TMAX_MIN);
                    end else if (wv > `VHM_TMAX_MAX) begin
                        tmax_next = 13'(`VHM_TMAX_MAX);
                    end else begin
                        tmax_next = wv[12:0];
                    end
                end
                `VHM_OFS_EVCLR: evst_next = evst_reg & ~i_avs_writedata[NE-1:0];
                `VHM_OFS_EVEN: even_next = i_avs_writedata[NE-1:0];
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        evst_next = evst_next | evt;
        if (i_avs_read && wait_reg) begin
            case (i_avs_address)
                `VHM_OFS_CTRL: rdata_next = {29'h0, ctrl_reg};
                `VHM_OFS_VTHR: rdata_next = {16'h0, vthr_reg};
                `VHM_OFS_ITHR: rdata_next = {16'h0, ithr_reg};
                `VHM_OFS_TMAX: rdata_next = {19'h0, tmax_reg};
                `VHM_OFS_STAT: rdata_next = {24'h0, state_reg, blk_reg, hold_reg,
                                             ct_reg, ihigh_reg, vlow_reg,
                                             ctrl_reg[`VHM_BIT_EN]};
                `VHM_OFS_EVST: rdata_next = {20'h0, evst_reg};
                `VHM_OFS_EVEN: rdata_next = {20'h0, even_reg};
                default:       rdata_next = 32'h0;
            endcase
        end
        irq_next = |(evst_reg & even_reg);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg  <= `VHM_CTRL_RST;
            vthr_reg  <= `VHM_VTHR_RST;
            ithr_reg  <= `VHM_ITHR_RST;
            tmax_reg  <= `VHM_TMAX_RST;
            even_reg  <= '0;
            evst_reg  <= '0;
            flg_prev  <= '0;
            rdata_reg <= 32'h0;
            wait_reg  <= 1'b1;
            irq_reg   <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            vthr_reg  <= vthr_next;
            ithr_reg  <= ithr_next;
            tmax_reg  <= tmax_next;
            even_reg  <= even_next;
            evst_reg  <= evst_next;
            flg_prev  <= flg_now;
            rdata_reg <= rdata_next;
            wait_reg  <= wait_next;
            irq_reg   <= irq_next;
        end
    end

    assign o_avs_readdata    = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_v_mag           = vmag_reg;
    assign o_v_ang           = vang_reg;
    assign o_hold_active     = hold_reg;
    assign o_ct_track        = ct_reg;
    assign o_irq             = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic [31:0] hcnt;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hcnt <= 32'h0;
        end else begin
            hcnt <= hold_reg ? hcnt + 32'h1 : 32'h0;
        end
    end

    sequence s_arm_ok;
        ctrl_reg[`VHM_BIT_EN] && state_reg == VHM_ARM
        && i_cycle_start && !i_block && act_cond;
    endsequence

    sequence s_expire;
        hold_reg && tmr_exp && !blk_next && ctrl_reg[`VHM_BIT_EN] ##1 !hold_reg;
    endsequence

    property p_dis;
        !ctrl_reg[`VHM_BIT_EN] |=> !o_hold_active ##1 !o_hold_active;
    endproperty
    a_dis: assert property (p_dis) else $error("hold while disabled");

    property p_vlow;
        $rose(o_hold_active) |-> $past(all_low) && $past(i_cycle_start);
    endproperty
    a_vlow: assert property (p_vlow) else $error("hold without low V");

    property p_ihigh;
        $rose(o_hold_active) && $past(ctrl_reg[`VHM_BIT_ISEL])
        |-> $past(any_high);
    endproperty
    a_ihigh: assert property (p_ihigh) else $error("hold without high I");

    property p_thr;
        vthr_reg >= `VHM_VTHR_MIN && vthr_reg <= `VHM_VTHR_MAX;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold out of range");

    property p_mag;
        o_hold_active |-> o_v_mag[0] == $past(vthr_reg)
                          && o_v_mag[2] == $past(vthr_reg);
    endproperty
    a_mag: assert property (p_mag) else $error("amplitude not substituted");

    property p_ang;
        o_hold_active ##1 o_hold_active |-> $stable(o_v_ang);
    endproperty
    a_ang: assert property (p_ang) else $error("angle moved in hold");

    property p_act;
        s_arm_ok |=> o_hold_active;
    endproperty
    a_act: assert property (p_act) else $error("hold did not start");

    property p_tmax;
        hold_reg |-> hcnt <= tmax_reg * P_TICK_CYC + 2;
    endproperty
    a_tmax: assert property (p_tmax) else $error("hold too long");

    property p_exp;
        s_expire |-> state_reg == VHM_DONE;
    endproperty
    a_exp: assert property (p_exp) else $error("expiry not taken");

    property p_blk;
        i_cycle_start && i_block |=> !o_hold_active;
    endproperty
    a_blk: assert property (p_blk) else $error("hold while blocked");

    property p_ct;
        o_ct_track |-> $past(ctrl_reg[`VHM_BIT_FCT]) && vlow_reg;
    endproperty
    a_ct: assert property (p_ct) else $error("tracking without cause");

    property p_evt;
        $rose(o_hold_active) |=> evst_reg[`VHM_EV_HOLD];
    endproperty
    a_evt: assert property (p_evt) else $error("hold-on event lost");
endmodule : vhm_top

// ---- test/vhm_far_stage.sv ----
`timescale 1ns/1ps
module vhm_far_stage #(
    parameter int P_VMIN = 16'h0064
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_hold_active,
    input  wire logic [2:0][15:0] i_v_mag,
    output logic                  o_unidir
);
    logic v_ok;
    logic unidir_next;

    // ****************************************
    // Directional decision of the stages
    // ****************************************
    always_comb begin
        v_ok = (i_v_mag[0] >= P_VMIN) || (i_v_mag[1] >= P_VMIN) || (i_v_mag[2] >= P_VMIN);
        // No polarising voltage and no hold: trip without direction
        unidir_next = !v_ok && !i_hold_active;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_unidir <= 1'b0;
        end else begin
            o_unidir <= unidir_next;
        end
    end
endmodule : vhm_far_stage

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "vhm_regs.svh"
module tb_top;
    localparam logic [15:0] VLO = 16'h0010;
    localparam logic [15:0] VHI = 16'h2000;
    localparam logic [15:0] VT  = 16'h03e8;

    logic                   i_clk;
    logic                   i_rst_n;
    logic [7:0]             i_avs_address;
    logic                   i_avs_read;
    logic                   i_avs_write;
    logic [31:0]            i_avs_writedata;
    logic [31:0]            o_avs_readdata;
    logic                   o_avs_waitrequest;
    logic                   i_cycle_start;
    logic                   i_block;
    logic [2:0]             i_v_used;
    logic [2:0][15:0]       i_v_mag;
    logic [2:0][15:0]       i_v_ang;
    logic [2:0][15:0]       i_i_mag;
    logic [2:0][15:0]       o_v_mag;
    logic [2:0][15:0]       o_v_ang;
    logic                   o_hold_active;
    logic                   o_ct_track;
    logic                   o_irq;
    logic                   far_unidir;
    int                     bad_count;
    int                     checked;

    vhm_top #(.P_W(16), .P_TICK_CYC(20)) vhm_top_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_cycle_start(i_cycle_start),
        .i_block(i_block), .i_v_used(i_v_used), .i_v_mag(i_v_mag), .i_v_ang(i_v_ang),
        .i_i_mag(i_i_mag), .o_v_mag(o_v_mag), .o_v_ang(o_v_ang),
        .o_hold_active(o_hold_active), .o_ct_track(o_ct_track), .o_irq(o_irq)
    );

    vhm_far_stage vhm_far_stage_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold_active(o_hold_active),
        .i_v_mag(o_v_mag), .o_unidir(far_unidir)
    );

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic end_of_test();
        $display("Counts: %0d comparisons, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_flag

    // ****************************************
    // Avalon-MM master and stimulus
    // ****************************************
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_address <= adr;
        i_avs_writedata <= wd;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (o_avs_waitrequest !== 1'b0) begin
            bad_count++;
            end_of_test();
        end
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, adr, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 32'h0, d);
        chk_val(d, exp);
    endtask : rd_chk

    task automatic rd_mask(input logic [7:0] adr, input logic [31:0] m);
        logic [31:0] d;
        bus(1'b0, adr, 32'h0, d);
        chk_val(d & m, m);
    endtask : rd_mask

    task automatic set_in(input logic [15:0] m0, input logic [15:0] mr,
                          input logic [15:0] ang, input logic [15:0] cur);
        @(posedge i_clk);
        i_v_mag <= {mr, mr, m0};
        i_v_ang <= {ang + 16'h0200, ang + 16'h0100, ang};
        i_i_mag <= {16'h0000, cur, 16'h0000};
    endtask : set_in

    task automatic pulse();
        @(posedge i_clk);
        i_cycle_start <= 1'b1;
        @(posedge i_clk);
        i_cycle_start <= 1'b0;
        @(negedge i_clk);
    endtask : pulse

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int n;
        bad_count = 0;
        checked = 0;
        i_rst_n = 1'b0;
        i_avs_address = 8'h00;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_cycle_start = 1'b0;
        i_block = 1'b0;
        i_v_used = 3'b111;
        i_v_mag = {VHI, VHI, VHI};
        i_v_ang = '0;
        i_i_mag = '0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd_chk(`VHM_OFS_CTRL, 32'h0);
        rd_chk(`VHM_OFS_VTHR, 32'h3e8);
        rd_chk(`VHM_OFS_ITHR, 32'h64);
        rd_chk(`VHM_OFS_TMAX, 32'h32);
        rd_chk(`VHM_OFS_EVST, 32'h0);
        rd_chk(`VHM_OFS_EVEN, 32'h0);
        wr(8'h24, 32'hffff_ffff);
        rd_chk(8'h24, 32'h0);
        wr(`VHM_OFS_STAT, 32'hff);
        rd_chk(`VHM_OFS_STAT, 32'h0);
        rd_chk(`VHM_OFS_EVCLR, 32'h0);
        wr(`VHM_OFS_VTHR, 32'h5);
        rd_chk(`VHM_OFS_VTHR, 32'hc8);
        wr(`VHM_OFS_VTHR, 32'hffff);
        rd_chk(`VHM_OFS_VTHR, 32'h1388);
        wr(`VHM_OFS_VTHR, {16'h0, VT});
        wr(`VHM_OFS_TMAX, 32'h0);
        rd_chk(`VHM_OFS_TMAX, 32'h2);
        wr(`VHM_OFS_TMAX, 32'h2000);
        rd_chk(`VHM_OFS_TMAX, 32'h1388);
        wr(`VHM_OFS_TMAX, 32'h2);
        $display("test registers done");

        set_in(VLO, VLO, 16'h0100, 16'h0);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        chk_val({16'h0, o_v_mag[1]}, {16'h0, VLO});
        set_in(VHI, VHI, 16'h0200, 16'h0);
        pulse();
        wr(`VHM_OFS_EVEN, 32'hfff);
        wr(`VHM_OFS_EVCLR, 32'hfff);
        wr(`VHM_OFS_CTRL, 32'h1);
        rd_chk(`VHM_OFS_EVST, 32'h1);
        @(negedge i_clk);
        chk_flag(o_irq, 1'b1);
        wr(`VHM_OFS_EVEN, 32'h0);
        repeat (2) @(negedge i_clk);
        chk_flag(o_irq, 1'b0);
        wr(`VHM_OFS_EVEN, 32'hfff);
        wr(`VHM_OFS_EVCLR, 32'hfff);
        repeat (2) @(negedge i_clk);
        chk_flag(o_irq, 1'b0);
        $display("test disabled and events done");

        set_in(VHI, VHI, 16'h0300, 16'h0);
        pulse();
        set_in(VHI, VLO, 16'h0400, 16'h0);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        set_in(VLO, VLO, 16'h0500, 16'h0);
        pulse();
        chk_flag(o_hold_active, 1'b1);
        for (int i = 0; i < 3; i++) begin
            chk_val({16'h0, o_v_mag[i]}, {16'h0, VT});
            chk_val({16'h0, o_v_ang[i]}, {16'h0, 16'h0400 + 16'(i * 256)});
        end
        n = 0;
        while (o_hold_active === 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        chk_flag(n >= 38 && n <= 46, 1'b1);
        repeat (2) @(negedge i_clk);
        chk_val({16'h0, o_v_mag[0]}, {16'h0, VLO});
        chk_flag(far_unidir, 1'b1);
        rd_chk(`VHM_OFS_EVST, 32'h304);
        wr(`VHM_OFS_EVCLR, 32'hfff);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        set_in(VHI, VHI, 16'h0600, 16'h0);
        pulse();
        repeat (2) @(negedge i_clk);
        chk_flag(far_unidir, 1'b0);
        $display("test hold and expiry done");

        wr(`VHM_OFS_CTRL, 32'h3);
        set_in(VLO, VLO, 16'h0700, 16'h0);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        set_in(VLO, VLO, 16'h0700, 16'h0064);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        set_in(VLO, VLO, 16'h0700, 16'h0065);
        pulse();
        chk_flag(o_hold_active, 1'b1);
        rd_chk(`VHM_OFS_STAT, 32'h97);
        @(posedge i_clk);
        i_block <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk_flag(o_hold_active, 1'b1);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        pulse();
        chk_flag(o_hold_active, 1'b0);
        @(posedge i_clk);
        i_block <= 1'b0;
        pulse();
        chk_flag(o_hold_active, 1'b1);
        wr(`VHM_OFS_CTRL, 32'h0);
        repeat (3) @(negedge i_clk);
        chk_flag(o_hold_active, 1'b0);
        rd_mask(`VHM_OFS_EVST, 32'hc12);
        wr(`VHM_OFS_EVCLR, 32'hfff);
        $display("test current and blocking done");

        wr(`VHM_OFS_CTRL, 32'h5);
        @(posedge i_clk);
        i_v_used <= 3'b110;
        set_in(VHI, VLO, 16'h0800, 16'h0);
        pulse();
        chk_flag(o_hold_active, 1'b1);
        repeat (2) @(negedge i_clk);
        chk_flag(o_ct_track, 1'b1);
        set_in(VHI, VHI, 16'h0900, 16'h0);
        pulse();
        repeat (2) @(negedge i_clk);
        chk_flag(o_ct_track, 1'b0);
        rd_mask(`VHM_OFS_EVST, 32'h0c0);
        $display("test used mask and tracking done");
        end_of_test();
    end
endmodule : tb_top
